// ---- inc/iep_pkg.sv ----
// Function
// - priority byte top bit reads one, resets rest
// - bits 6..0 pick low/high level per source
// - priority byte at 0xB8, bit and byte access
// - enable bit 7 gates both timer3 overflows
// - enable bit 4 gates all counter array requests
// - enable bit 1 gates all usb requests
// - enable bit 0 gates the smbus request
// - extended priority bit 7 sets timer3 level
// - extended priority bit 4 sets counter array level
// - extended priority bit 1 sets usb level
// - extended priority bit 0 sets smbus level
// - second enable upper nibble reads zero
// - second enable bit 3 gates port match
// - second enable bit 1 gates uart one
// - second enable bit 0 gates bus supply sense
// - global enable overrides every individual mask
package iep_pkg;

  localparam logic [7:0] ADDR_PRIO0    = 8'hB8;
  localparam logic [7:0] ADDR_EN1      = 8'hE6;
  localparam logic [7:0] ADDR_EN2      = 8'hE7;
  localparam logic [7:0] ADDR_PRIO1    = 8'hF6;

  localparam logic [6:0] RST_PRIO0     = 7'h00;
  localparam logic [7:0] RST_EN1       = 8'h00;
  localparam logic [7:0] RST_PRIO1     = 8'h00;
  localparam logic [3:0] RST_EN2       = 4'h0;
  localparam logic [7:0] RST_RDATA     = 8'h00;

  localparam int         PRIO0_TOP     = 7;
  localparam int         EN2_WIDTH     = 4;

  localparam int         BIT_TIMER3    = 7;
  localparam int         BIT_PCA       = 4;
  localparam int         BIT_USB       = 1;
  localparam int         BIT_SMB       = 0;
  localparam int         BIT_MATCH     = 3;
  localparam int         BIT_UART1     = 1;
  localparam int         BIT_VBUS      = 0;

  // source index is also the fixed polling order, lowest first
  localparam int         NSRC          = 14;
  localparam int         NCLASSIC      = 7;
  localparam logic [3:0] SRC_SMB       = 4'h7;
  localparam logic [3:0] SRC_USB       = 4'h8;
  localparam logic [3:0] SRC_PCA       = 4'h9;
  localparam logic [3:0] SRC_TIMER3    = 4'hA;
  localparam logic [3:0] SRC_VBUS      = 4'hB;
  localparam logic [3:0] SRC_UART1     = 4'hC;
  localparam logic [3:0] SRC_MATCH     = 4'hD;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic       bit_val;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iep_sfr_s;

  typedef struct packed {
    logic       match;
    logic       uart1;
    logic       vbus;
    logic       timer3_high_overflow;
    logic       timer3_low_overflow;
    logic       pca;
    logic       usb;
    logic       smb;
    logic [6:0] classic;
  } iep_src_s;

  typedef struct packed {
    logic       req;
    logic       hi;
    logic [3:0] idx;
  } iep_grant_s;

endpackage

// ---- hw/iep_core.sv ----
module iep_core (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                arst_n,
  // special function register port
  input  wire iep_pkg::iep_sfr_s   sfr,
  output      logic [7:0]          sfr_rdata,
  // peripheral requests and external controls
  input  wire iep_pkg::iep_src_s   src,
  input  wire logic                global_irq_en,
  input  wire logic [6:0]          classic_en,
  input  wire logic [7:0]          prio_second,
  // cpu core side
  input  wire logic                irq_ack,
  input  wire logic                irq_ret,
  output      iep_pkg::iep_grant_s grant
);

  logic [6:0]          prio0_q;
  logic [6:0]          prio0_d;
  logic [7:0]          en1_q;
  logic [7:0]          en1_d;
  logic [7:0]          prio1_q;
  logic [7:0]          prio1_d;
  logic [3:0]          en2_q;
  logic [3:0]          en2_d;
  logic [7:0]          rdata_q;
  logic [7:0]          rdata_d;
  logic                in_lo_q;
  logic                in_lo_d;
  logic                in_hi_q;
  logic                in_hi_d;
  iep_pkg::iep_grant_s grant_q;
  iep_pkg::iep_grant_s grant_d;

  logic [iep_pkg::NSRC-1:0] req_vec;
  logic [iep_pkg::NSRC-1:0] en_vec;
  logic [iep_pkg::NSRC-1:0] prio_vec;
  logic [iep_pkg::NSRC-1:0] pend;
  logic [iep_pkg::NSRC-1:0] hi_pend;
  logic [iep_pkg::NSRC-1:0] lo_pend;
  logic                     bit_hit;

  assign sfr_rdata = rdata_q;
  assign grant     = grant_q;

  // register file
  assign bit_hit = sfr.bit_wr &&
                   (sfr.addr[7:3] == iep_pkg::ADDR_PRIO0[7:3]);

  always_comb begin
    prio0_d = prio0_q;
    en1_d   = en1_q;
    prio1_d = prio1_q;
    en2_d   = en2_q;
    rdata_d = rdata_q;
    if (sfr.wr) begin
      unique case (sfr.addr)
        iep_pkg::ADDR_PRIO0: prio0_d = sfr.wdata[6:0];
        iep_pkg::ADDR_EN1:   en1_d   = sfr.wdata;
        iep_pkg::ADDR_PRIO1: prio1_d = sfr.wdata;
        iep_pkg::ADDR_EN2:   en2_d   = sfr.wdata[3:0];
        default: ;
      endcase
    end
    // bit 7 is a constant one, so a bit write there is dropped
    if (bit_hit && sfr.addr[2:0] != 3'h7) begin
      prio0_d[sfr.addr[2:0]] = sfr.bit_val;
    end
    if (sfr.rd) begin
      unique case (sfr.addr)
        iep_pkg::ADDR_PRIO0: rdata_d = {1'b1, prio0_q};
        iep_pkg::ADDR_EN1:   rdata_d = en1_q;
        iep_pkg::ADDR_PRIO1: rdata_d = prio1_q;
        iep_pkg::ADDR_EN2:   rdata_d = {4'h0, en2_q};
        default:             rdata_d = iep_pkg::RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prio0_q <= iep_pkg::RST_PRIO0;
      en1_q   <= iep_pkg::RST_EN1;
      prio1_q <= iep_pkg::RST_PRIO1;
      en2_q   <= iep_pkg::RST_EN2;
      rdata_q <= iep_pkg::RST_RDATA;
    end else begin
      prio0_q <= prio0_d;
      en1_q   <= en1_d;
      prio1_q <= prio1_d;
      en2_q   <= en2_d;
      rdata_q <= rdata_d;
    end
  end

  // source vectors in polling order
  assign req_vec = {src.match, src.uart1, src.vbus,
                    src.timer3_high_overflow | src.timer3_low_overflow,
                    src.pca, src.usb, src.smb, src.classic};

  assign en_vec = {en2_q[iep_pkg::BIT_MATCH],
                   en2_q[iep_pkg::BIT_UART1],
                   en2_q[iep_pkg::BIT_VBUS],
                   en1_q[iep_pkg::BIT_TIMER3],
                   en1_q[iep_pkg::BIT_PCA],
                   en1_q[iep_pkg::BIT_USB],
                   en1_q[iep_pkg::BIT_SMB],
                   classic_en};

  assign prio_vec = {prio_second[iep_pkg::BIT_MATCH],
                     prio_second[iep_pkg::BIT_UART1],
                     prio_second[iep_pkg::BIT_VBUS],
                     prio1_q[iep_pkg::BIT_TIMER3],
                     prio1_q[iep_pkg::BIT_PCA],
                     prio1_q[iep_pkg::BIT_USB],
                     prio1_q[iep_pkg::BIT_SMB],
                     prio0_q};

  assign pend    = req_vec & en_vec & {iep_pkg::NSRC{global_irq_en}};
  assign hi_pend = pend & prio_vec;
  assign lo_pend = pend & ~prio_vec;

  // in-service levels and the next grant
  always_comb begin
    in_lo_d = in_lo_q;
    in_hi_d = in_hi_q;
    grant_d = '0;
    // return pops the innermost level first
    if (irq_ret) begin
      if (in_hi_q) begin
        in_hi_d = 1'b0;
      end else begin
        in_lo_d = 1'b0;
      end
    end
    // an ack in the same cycle as a return still enters service
    if (irq_ack && grant_q.req) begin
      if (grant_q.hi) begin
        in_hi_d = 1'b1;
      end else begin
        in_lo_d = 1'b1;
      end
    end
    // judged on next levels so a taken grant drops at once
    for (int i = iep_pkg::NSRC - 1; i >= 0; i--) begin
      if (lo_pend[i] && !in_lo_d && !in_hi_d) begin
        grant_d.req = 1'b1;
        grant_d.idx = 4'(i);
      end
    end
    for (int i = iep_pkg::NSRC - 1; i >= 0; i--) begin
      if (hi_pend[i] && !in_hi_d) begin
        grant_d.req = 1'b1;
        grant_d.hi  = 1'b1;
        grant_d.idx = 4'(i);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      in_lo_q <= 1'b0;
      in_hi_q <= 1'b0;
      grant_q <= '0;
    end else begin
      in_lo_q <= in_lo_d;
      in_hi_q <= in_hi_d;
      grant_q <= grant_d;
    end
  end

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence prio0_read_s;
    sfr.rd && sfr.addr == iep_pkg::ADDR_PRIO0;
  endsequence

  sequence hi_waiting_s;
    (|hi_pend) && !in_hi_q && !irq_ack && !grant_q.req;
  endsequence

  prio_top_a: assert property (
    prio0_read_s |=> sfr_rdata[iep_pkg::PRIO0_TOP])
    else $error("priority top bit read as zero");

  prio_bitwr_a: assert property (
    bit_hit && !sfr.wr && sfr.addr[2:0] != 3'h7
    |=> prio0_q[$past(sfr.addr[2:0])] == $past(sfr.bit_val))
    else $error("bit write to priority byte lost");

  en2_upper_a: assert property (
    sfr.rd && sfr.addr == iep_pkg::ADDR_EN2 |=> sfr_rdata[7:4] == 4'h0)
    else $error("second enable upper nibble not zero");

  en1_write_a: assert property (
    sfr.wr && sfr.addr == iep_pkg::ADDR_EN1 |=> en1_q == $past(sfr.wdata))
    else $error("first enable write not stored");

  global_off_a: assert property (
    !global_irq_en |=> !grant_q.req)
    else $error("grant raised with global enable low");

  timer3_mask_a: assert property (
    grant_q.req && grant_q.idx == iep_pkg::SRC_TIMER3
    |-> $past(en1_q[iep_pkg::BIT_TIMER3]))
    else $error("timer3 granted while masked");

  pca_mask_a: assert property (
    grant_q.req && grant_q.idx == iep_pkg::SRC_PCA
    |-> $past(en1_q[iep_pkg::BIT_PCA]))
    else $error("counter array granted while masked");

  usb_mask_a: assert property (
    grant_q.req && grant_q.idx == iep_pkg::SRC_USB
    |-> $past(en1_q[iep_pkg::BIT_USB]))
    else $error("usb granted while masked");

  smb_mask_a: assert property (
    grant_q.req && grant_q.idx == iep_pkg::SRC_SMB
    |-> $past(en1_q[iep_pkg::BIT_SMB]))
    else $error("smbus granted while masked");

  match_mask_a: assert property (
    grant_q.req && grant_q.idx == iep_pkg::SRC_MATCH
    |-> $past(en2_q[iep_pkg::BIT_MATCH]))
    else $error("port match granted while masked");

  uart1_mask_a: assert property (
    grant_q.req && grant_q.idx == iep_pkg::SRC_UART1
    |-> $past(en2_q[iep_pkg::BIT_UART1]))
    else $error("uart one granted while masked");

  vbus_mask_a: assert property (
    grant_q.req && grant_q.idx == iep_pkg::SRC_VBUS
    |-> $past(en2_q[iep_pkg::BIT_VBUS]))
    else $error("bus supply granted while masked");

  grant_level_a: assert property (
    grant_q.req |-> grant_q.hi == 1'($past(prio_vec) >> grant_q.idx))
    else $error("grant level differs from priority bit");

  preempt_a: assert property (
    hi_waiting_s |=> grant_q.req && grant_q.hi)
    else $error("high request did not preempt");

  hi_blocks_a: assert property (
    in_hi_q && !irq_ret |=> !grant_q.req)
    else $error("grant raised during high handler");

  lo_waits_a: assert property (
    in_lo_q && !irq_ret |=> !grant_q.req || grant_q.hi)
    else $error("low grant during low handler");

  prio_write_a: assert property (
    sfr.wr && !sfr.bit_wr && sfr.addr == iep_pkg::ADDR_PRIO0
    |=> prio0_q == $past(sfr.wdata[6:0]))
    else $error("byte write to priority byte lost");

  prio1_write_a: assert property (
    sfr.wr && sfr.addr == iep_pkg::ADDR_PRIO1 |=> prio1_q == $past(sfr.wdata))
    else $error("extended priority write not stored");

  en2_write_a: assert property (
    sfr.wr && sfr.addr == iep_pkg::ADDR_EN2 |=> en2_q == $past(sfr.wdata[3:0]))
    else $error("second enable write not stored");

  prio_bit7_a: assert property (
    bit_hit && !sfr.wr && sfr.addr[2:0] == 3'h7
    |=> $stable(prio0_q))
    else $error("bit write to unused top bit changed state");

  rd_hold_a: assert property (
    !sfr.rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  hi_ack_a: assert property (
    irq_ack && grant_q.req && grant_q.hi |=> !grant_q.req)
    else $error("grant kept after high request was taken");

  hi_first_a: assert property (
    (|hi_pend) && !in_hi_q && !irq_ack |=> grant_q.req && grant_q.hi)
    else $error("low grant chosen over pending high request");

  t3_low_a: assert property (
    src.timer3_low_overflow && en1_q[iep_pkg::BIT_TIMER3] && global_irq_en
    |-> pend[iep_pkg::SRC_TIMER3])
    else $error("timer3 low overflow not passed");

  t3_high_a: assert property (
    src.timer3_high_overflow && en1_q[iep_pkg::BIT_TIMER3] && global_irq_en
    |-> pend[iep_pkg::SRC_TIMER3])
    else $error("timer3 high overflow not passed");

  smb_pass_a: assert property (
    src.smb && en1_q[iep_pkg::BIT_SMB] && global_irq_en
    |-> pend[iep_pkg::SRC_SMB])
    else $error("smbus request not passed");

endmodule

// ---- dv/iep_cpu_model.sv ----
module iep_cpu_model (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                arst_n,
  // bench controls: accept low models a slow core
  input  wire logic                accept,
  input  wire logic                ret_cmd,
  // controller side
  input  wire iep_pkg::iep_grant_s grant,
  output      logic                irq_ack,
  output      logic                irq_ret
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ack_d;
  logic ret_d;

  always_comb begin
    // one ack per offered grant, none without an offer
    ack_d = accept & grant.req & ~irq_ack;
    ret_d = ret_cmd;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ack <= 1'b0;
      irq_ret <= 1'b0;
    end else begin
      irq_ack <= ack_d;
      irq_ret <= ret_d;
    end
  end
endmodule

// ---- dv/iep_core_tb.sv ----
module iep_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                mclk = 1'b0;
  logic                arst_n = 1'b0;
  iep_pkg::iep_sfr_s   sfr = '0;
  iep_pkg::iep_src_s   src = '0;
  logic                gen = 1'b1;
  logic [6:0]          cen = 7'h7F;
  logic [7:0]          p2 = 8'h00;
  logic                accept = 1'b0;
  logic                ret_cmd = 1'b0;
  logic                ack;
  logic                ret;
  logic [7:0]          rdata;
  iep_pkg::iep_grant_s grant;
  int                  n_fail = 0;
  int                  checks = 0;

  iep_core DUT (.mclk(mclk), .arst_n(arst_n), .sfr(sfr), .sfr_rdata(rdata),
    .src(src), .global_irq_en(gen), .classic_en(cen), .prio_second(p2),
    .irq_ack(ack), .irq_ret(ret), .grant(grant));
  iep_cpu_model cpu (.mclk(mclk), .arst_n(arst_n), .accept(accept),
    .ret_cmd(ret_cmd), .grant(grant), .irq_ack(ack), .irq_ret(ret));

  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    tick(1);
    sfr.wr = 1'b0;
    tick(1);
  endtask

  task automatic bwr(input logic [7:0] a, input logic v);
    sfr.bit_wr = 1'b1;
    sfr.addr = a;
    sfr.bit_val = v;
    tick(1);
    sfr.bit_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr.rd = 1'b1;
    sfr.addr = a;
    tick(1);
    sfr.rd = 1'b0;
    chk(rdata, exp);
    tick(1);
  endtask

  task automatic gchk(input logic r, input logic h, input logic [3:0] i);
    chk({2'b00, grant}, {2'b00, r, h, i});
  endtask

  task automatic regs_test;
    rd(8'hB8, 8'h80);
    rd(8'hE6, 8'h00);
    rd(8'hE7, 8'h00);
    rd(8'hF6, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'hFF);
    wr(8'hB8, 8'h00);
    rd(8'hB8, 8'h80);
    bwr(8'hBF, 1'b0);
    bwr(8'hBE, 1'b1);
    rd(8'hB8, 8'hC0);
    bwr(8'hBE, 1'b0);
    wr(8'hE7, 8'hFB);
    rd(8'hE7, 8'h0B);
    wr(8'hE7, 8'h00);
    wr(8'hE6, 8'h93);
    rd(8'hE6, 8'h93);
    wr(8'hE6, 8'h00);
    wr(8'hF6, 8'h93);
    rd(8'hF6, 8'h93);
    wr(8'hF6, 8'h00);
  endtask

  // source bit, enable address, enable bit, expected index
  task automatic gate_test;
    int sb[8] = '{7, 8, 9, 10, 11, 12, 13, 14};
    int eb[8] = '{0, 1, 4, 7, 7, 0, 1, 3};
    int ix[8] = '{7, 8, 9, 10, 10, 11, 12, 13};
    logic [7:0] ea;
    for (int i = 0; i < 8; i++) begin
      ea = (i < 5) ? 8'hE6 : 8'hE7;
      src = iep_pkg::iep_src_s'(15'h0001 << sb[i]);
      tick(3);
      gchk(1'b0, 1'b0, 4'h0);
      wr(ea, 8'(1 << eb[i]));
      tick(3);
      gchk(1'b1, 1'b0, 4'(ix[i]));
      if (i < 5) wr(8'hF6, 8'(1 << eb[i]));
      else p2 = 8'(1 << eb[i]);
      tick(3);
      gchk(1'b1, 1'b1, 4'(ix[i]));
      gen = 1'b0;
      tick(3);
      gchk(1'b0, 1'b0, 4'h0);
      gen = 1'b1;
      src = '0;
      p2 = 8'h00;
      wr(ea, 8'h00);
      wr(8'hF6, 8'h00);
    end
  endtask

  task automatic classic_test;
    for (int n = 0; n < 7; n++) begin
      src = iep_pkg::iep_src_s'(15'h0001 << n);
      bwr(8'(8'hB8 + n), 1'b1);
      tick(3);
      gchk(1'b1, 1'b1, 4'(n));
      bwr(8'(8'hB8 + n), 1'b0);
      tick(3);
      gchk(1'b1, 1'b0, 4'(n));
    end
    src = '0;
  endtask

  task automatic take(input int n);
    accept = 1'b1;
    tick(2);
    accept = 1'b0;
    tick(n);
  endtask

  task automatic ret_pulse;
    ret_cmd = 1'b1;
    tick(1);
    ret_cmd = 1'b0;
    tick(3);
  endtask

  task automatic nest_test;
    wr(8'hE6, 8'h03);
    wr(8'hF6, 8'h02);
    src.smb = 1'b1;
    tick(3);
    gchk(1'b1, 1'b0, 4'h7);
    take(2);
    src.classic[0] = 1'b1;
    tick(3);
    gchk(1'b0, 1'b0, 4'h0);
    src.usb = 1'b1;
    tick(3);
    gchk(1'b1, 1'b1, 4'h8);
    take(2);
    gchk(1'b0, 1'b0, 4'h0);
    src.usb = 1'b0;
    ret_pulse();
    gchk(1'b0, 1'b0, 4'h0);
    ret_pulse();
    gchk(1'b1, 1'b0, 4'h0);
  endtask

  initial begin
    #50us;
    n_fail++;
    end_of_test();
  end

  initial begin
    tick(3);
    arst_n = 1'b1;
    tick(1);
    chk(rdata, 8'h00);
    gchk(1'b0, 1'b0, 4'h0);
    regs_test();
    gate_test();
    classic_test();
    nest_test();
    end_of_test();
  end
endmodule
